/* File: hw/lutrom_top.sv */
// Look-up table block: address path, storage and bus register view.
//
// Contract
// - The table holds two to the address width words, one per address.
// - Address width is a build choice from 2 to 16, address is unsigned.
// - Word format is signed, signed fraction, unsigned or single bit.
// - In the signed formats, integer bits include the sign, which is the top output bit.
// - Fraction bits apply only to the fraction format, a bit is one wide.
// - Contents come from a short initial array and misfits are flagged.
// - An optional enable input gates the address and output registers.
// - Registered output adds one clock of read latency.
// - Registered address is captured one edge before the lookup uses it.
// - The library style always registers the address.
`timescale 1ns/1ps
`default_nettype none
module lutrom_top
   import lutrom_pkg::*;
#(
   parameter int             ADDR_W     = 8,
   parameter lutrom_fmt_type FMT        = LUTROM_SINT,
   parameter int             INT_BITS   = 8,
   parameter int             FRAC_BITS  = 0,
   parameter bit             USE_ENA    = 1'b1,
   parameter bit             REG_DATA   = 1'b1,
   parameter bit             REG_ADDR   = 1'b0,
   parameter bit             USE_LIBROM = 1'b0,
   parameter int             INIT_LEN   = 4,
   parameter logic signed [31:0] INIT_VALS [INIT_LEN] = '{default: 32'sh0},
   // Derived; not meant to be overridden.
   parameter int             DATA_W =
      (FMT == LUTROM_BIT) ? 1 :
      (FMT == LUTROM_SFRAC) ? INT_BITS + FRAC_BITS : INT_BITS
)
(
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              sys_rst,
   // Lookup datapath
   input  wire logic [ADDR_W-1:0] lut_addr,
   input  wire logic              lut_ena,
   output var  logic [DATA_W-1:0] lut_data,
   // Register bus
   input  wire lutrom_wb_req_type wb_req,
   output var  lutrom_wb_rsp_type wb_rsp,
   // Build check
   output var  logic              init_inexact
);

   // The address width is bounded at build time; an illegal width holds
   // the lookup enable low instead of running a silently wrong table.
   localparam bit ADDR_OK = (ADDR_W >= LUTROM_ADDR_W_MIN) &&
                            (ADDR_W <= LUTROM_ADDR_W_MAX);

   // The library style forces the address stage.
   localparam bit ADDR_STAGE = REG_ADDR || USE_LIBROM;

   // Read latency in clocks, published on the bus.
   localparam logic [3:0] LATENCY =
      4'(int'(ADDR_STAGE) + int'(REG_DATA));

   localparam bit SIGNED_FMT = (FMT == LUTROM_SINT) ||
                               (FMT == LUTROM_SFRAC);

   // Fraction bits that the format really uses.
   localparam logic [7:0] FRAC_EFF =
      (FMT == LUTROM_SFRAC) ? 8'(FRAC_BITS) : 8'h00;

   localparam logic [4:0] ADDR_W_CODE = 5'(ADDR_W);
   localparam int         PAD_W       = 32 - DATA_W;
   localparam int         APAD_W      = 32 - ADDR_W;

   // Control and status state.
   logic              hold_q;
   logic              hold_d;
   logic              soft_q;
   logic              soft_d;
   logic [ADDR_W-1:0] saddr_q;
   logic [ADDR_W-1:0] saddr_d;
   logic [31:0]       count_q;
   logic [31:0]       count_d;
   logic              ack_q;
   logic              ack_d;
   logic [31:0]       rdat_q;
   logic [31:0]       rdat_d;
   logic [ADDR_W-1:0] addr_q;
   logic [ADDR_W-1:0] addr_d;

   // Datapath wires.
   logic              ena_w;
   logic              adv_w;
   logic [ADDR_W-1:0] src_addr_w;
   logic [ADDR_W-1:0] look_addr_w;
   logic [DATA_W-1:0] word_w;
   logic              inexact_w;
   logic              sign_w;
   logic [31:0]       data_view_w;
   logic [31:0]       saddr_view_w;

   // Bus decode wires.
   logic              req_w;
   logic              wr_w;
   logic              rd_hit_ctrl_w;
   logic              hit_ctrl_w;
   logic              hit_stat_w;
   logic              hit_data_w;
   logic              hit_saddr_w;
   logic              hit_count_w;
   logic              hit_info_w;
   logic              wr_ctrl_w;
   logic              wr_saddr_w;
   logic              wr_count_w;
   logic [31:0]       ctrl_view_w;
   logic [31:0]       stat_view_w;
   logic [31:0]       info_view_w;

   // Enable path: the port is used only when asked for; software can also
   // freeze the block, which acts like the enable held low.
   assign ena_w = USE_ENA ? lut_ena : 1'b1;
   assign adv_w = ena_w && !hold_q && ADDR_OK;

   // Address source: the datapath port, or the software address register.
   assign src_addr_w = soft_q ? saddr_q : lut_addr;

   // The lookup reads the captured address when that stage exists.
   assign look_addr_w = ADDR_STAGE ? addr_q : src_addr_w;

   // Address stage; it holds while the enable is low.
   assign addr_d = adv_w ? src_addr_w : addr_q;

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         addr_q <= '0;
      else
         addr_q <= addr_d;
   end

   // Table storage and the optional output register.
   lutrom_mem #(
      .ADDR_W    (ADDR_W),
      .DATA_W    (DATA_W),
      .FMT       (FMT),
      .REG_OUT   (REG_DATA),
      .INIT_LEN  (INIT_LEN),
      .INIT_VALS (INIT_VALS)
   ) u_mem (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .rd_en   (adv_w),
      .rd_addr (look_addr_w),
      .rd_data (word_w),
      .inexact (inexact_w)
   );

   // The word leaves in its stored format; MSB is the sign where signed.
   assign lut_data     = word_w;
   assign init_inexact = inexact_w;

   // Bus view of the current word, sign-extended for signed formats.
   assign sign_w      = SIGNED_FMT ? word_w[DATA_W-1] : 1'b0;
   assign data_view_w = {{PAD_W{sign_w}}, word_w};
   assign saddr_view_w = {{APAD_W{1'b0}}, saddr_q};

   // Register bus decode.
   assign req_w       = wb_req.cyc && wb_req.stb && !ack_q;
   assign wr_w        = req_w && wb_req.we;
   assign hit_ctrl_w  = (wb_req.adr == LUTROM_REG_CTRL);
   assign hit_stat_w  = (wb_req.adr == LUTROM_REG_STATUS);
   assign hit_data_w  = (wb_req.adr == LUTROM_REG_DATA);
   assign hit_saddr_w = (wb_req.adr == LUTROM_REG_SADDR);
   assign hit_count_w = (wb_req.adr == LUTROM_REG_COUNT);
   assign hit_info_w  = (wb_req.adr == LUTROM_REG_INFO);
   assign rd_hit_ctrl_w = hit_ctrl_w;
   assign wr_ctrl_w   = wr_w && hit_ctrl_w && wb_req.sel[0];
   assign wr_saddr_w  = wr_w && hit_saddr_w;
   assign wr_count_w  = wr_w && hit_count_w;

   // Read views.
   assign ctrl_view_w = {30'h0000_0000, soft_q, hold_q};
   assign stat_view_w = {30'h0000_0000, adv_w, inexact_w};
   assign info_view_w = {4'h0, LATENCY, FRAC_EFF,
                         6'h00, FMT, 3'h0, ADDR_W_CODE};

   // Control register.
   assign hold_d = wr_ctrl_w ? wb_req.dat[LUTROM_CTRL_HOLD] : hold_q;
   assign soft_d = wr_ctrl_w ? wb_req.dat[LUTROM_CTRL_SOFT] : soft_q;

   // Software address, written byte by byte; upper bits are dropped.
   always_comb
   begin
      saddr_d = saddr_q;
      for (int b = 0; b < ADDR_W; b++)
      begin
         if (wr_saddr_w && wb_req.sel[b / 8])
            saddr_d[b] = wb_req.dat[b];
      end
   end

   // Lookup counter: counts enabled cycles; a write clears it, and a count
   // in the clearing cycle is kept.
   always_comb
   begin
      count_d = count_q;
      if (wr_count_w)
         count_d = LUTROM_COUNT_RST;
      if (adv_w)
         count_d = count_d + 32'h0000_0001;
   end

   // Read mux; unmapped offsets answer with zero.
   always_comb
   begin
      rdat_d = 32'h0000_0000;
      if (rd_hit_ctrl_w)
         rdat_d = ctrl_view_w;
      else if (hit_stat_w)
         rdat_d = stat_view_w;
      else if (hit_data_w)
         rdat_d = data_view_w;
      else if (hit_saddr_w)
         rdat_d = saddr_view_w;
      else if (hit_count_w)
         rdat_d = count_q;
      else if (hit_info_w)
         rdat_d = info_view_w;
   end

   // Every request is answered one cycle after it is seen.
   assign ack_d = req_w;

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         hold_q  <= LUTROM_CTRL_RST[LUTROM_CTRL_HOLD];
         soft_q  <= LUTROM_CTRL_RST[LUTROM_CTRL_SOFT];
         saddr_q <= '0;
         count_q <= LUTROM_COUNT_RST;
         ack_q   <= 1'b0;
         rdat_q  <= 32'h0000_0000;
      end
      else
      begin
         hold_q  <= hold_d;
         soft_q  <= soft_d;
         saddr_q <= saddr_d;
         count_q <= count_d;
         ack_q   <= ack_d;
         rdat_q  <= rdat_d;
      end
   end

   assign wb_rsp.ack = ack_q;
   assign wb_rsp.dat = rdat_q;

endmodule : lutrom_top
`default_nettype wire

/* File: include/lutrom_pkg.sv */
// Shared constants, formats and bus carriers of the look-up table block.
package lutrom_pkg;

   // Stored word formats.
   typedef enum logic [1:0]
   {
      LUTROM_SINT  = 2'b00,
      LUTROM_SFRAC = 2'b01,
      LUTROM_UINT  = 2'b10,
      LUTROM_BIT   = 2'b11
   } lutrom_fmt_type;

   // Legal address widths.
   localparam int LUTROM_ADDR_W_MIN = 2;
   localparam int LUTROM_ADDR_W_MAX = 16;

   // Widest stored word that the bus view can sign-extend.
   localparam int LUTROM_DATA_W_MAX = 31;

   // Width of one initial value.
   localparam int LUTROM_INIT_W = 32;

   // Register bus geometry and register byte offsets.
   localparam int          LUTROM_WB_ADR_W = 8;
   localparam logic [7:0]  LUTROM_REG_CTRL   = 8'h00;
   localparam logic [7:0]  LUTROM_REG_STATUS = 8'h04;
   localparam logic [7:0]  LUTROM_REG_DATA   = 8'h08;
   localparam logic [7:0]  LUTROM_REG_SADDR  = 8'h0C;
   localparam logic [7:0]  LUTROM_REG_COUNT  = 8'h10;
   localparam logic [7:0]  LUTROM_REG_INFO   = 8'h14;

   // Field positions.
   localparam int LUTROM_CTRL_HOLD   = 0;
   localparam int LUTROM_CTRL_SOFT   = 1;
   localparam int LUTROM_STAT_INEX   = 0;
   localparam int LUTROM_STAT_ADV    = 1;
   localparam int LUTROM_INFO_FMT    = 8;
   localparam int LUTROM_INFO_FRAC   = 16;
   localparam int LUTROM_INFO_LAT    = 24;

   // Values after reset.
   localparam logic [1:0]  LUTROM_CTRL_RST  = 2'h0;
   localparam logic [31:0] LUTROM_COUNT_RST = 32'h0000_0000;

   // Classic bus request and answer.
   typedef struct packed
   {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } lutrom_wb_req_type;

   typedef struct packed
   {
      logic        ack;
      logic [31:0] dat;
   } lutrom_wb_rsp_type;

endpackage : lutrom_pkg

/* File: hw/lutrom_mem.sv */
// Fixed table storage with optional registered read data.
`timescale 1ns/1ps
`default_nettype none
module lutrom_mem
   import lutrom_pkg::*;
#(
   parameter int             ADDR_W   = 8,
   parameter int             DATA_W   = 8,
   parameter lutrom_fmt_type FMT      = LUTROM_SINT,
   parameter bit             REG_OUT  = 1'b1,
   parameter int             INIT_LEN = 4,
   parameter logic signed [31:0] INIT_VALS [INIT_LEN] = '{default: 32'sh0}
)
(
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              sys_rst,
   // Read port
   input  wire logic              rd_en,
   input  wire logic [ADDR_W-1:0] rd_addr,
   output var  logic [DATA_W-1:0] rd_data,
   // Build check
   output var  logic              inexact
);

   localparam int DEPTH = 1 << ADDR_W;
   localparam bit SIGNED_FMT = (FMT == LUTROM_SINT) || (FMT == LUTROM_SFRAC);

   logic [DATA_W-1:0] table_w [DEPTH];
   logic [DEPTH-1:0]  bad_w;
   logic              inexact_q;

   function automatic logic fits(input logic signed [31:0] v);
      logic signed [33:0] lo;
      logic signed [33:0] hi;
      lo = SIGNED_FMT ? -(34'sh1 <<< (DATA_W - 1)) : 34'sh0;
      hi = SIGNED_FMT ? (34'sh1 <<< (DATA_W - 1)) - 34'sh1
                      : (34'sh1 <<< DATA_W) - 34'sh1;
      return (34'(v) >= lo) && (34'(v) <= hi);
   endfunction : fits

   // Each address owns one word; entries past the initial array are zero.
   for (genvar i = 0; i < DEPTH; i++)
   begin : g_entry
      if (i < INIT_LEN)
      begin : g_init
         assign table_w[i] = INIT_VALS[i][DATA_W-1:0];
         assign bad_w[i]   = !fits(INIT_VALS[i]);
      end
      else
      begin : g_zero
         assign table_w[i] = '0;
         assign bad_w[i]   = 1'b0;
      end
   end

   // An array as long as the table is also flagged.
   always_ff @(posedge clk_sys)
   begin
      inexact_q <= (|bad_w) || (INIT_LEN >= DEPTH);
   end
   assign inexact = inexact_q;

   if (REG_OUT)
   begin : g_reg
      logic [DATA_W-1:0] data_q;
      always_ff @(posedge clk_sys)
      begin
         if (sys_rst)
            data_q <= '0;
         else if (rd_en)
            data_q <= table_w[rd_addr];
      end
      assign rd_data = data_q;
   end
   else
   begin : g_comb
      assign rd_data = table_w[rd_addr];
   end

endmodule : lutrom_mem
`default_nettype wire

/* File: bench/lutrom_checker.sv */
// Port-level assertions for the look-up table block.
`timescale 1ns/1ps
`default_nettype none
module lutrom_checker
   import lutrom_pkg::*;
#(
   parameter int ADDR_W   = 8,
   parameter int DATA_W   = 8,
   parameter int INIT_LEN = 4
)
(
   // Clock and reset
   input wire logic              clk_sys,
   input wire logic              sys_rst,
   // Lookup datapath
   input wire logic [ADDR_W-1:0] lut_addr,
   input wire logic              lut_ena,
   input wire logic [DATA_W-1:0] lut_data,
   // Register bus
   input wire lutrom_wb_req_type wb_req,
   input wire lutrom_wb_rsp_type wb_rsp,
   // Build check
   input wire logic              init_inexact
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   wire rd_take = wb_req.cyc && wb_req.stb && !wb_rsp.ack && !wb_req.we;

   property p_hold; !lut_ena |=> $stable(lut_data); endproperty
   a_hold: assert property (p_hold)
      else $error("lookup output moved while disabled");
   property p_cause; $changed(lut_data) |-> $past(lut_ena); endproperty
   a_cause: assert property (p_cause)
      else $error("lookup output moved without an enabled edge");
   property p_zero;
      lut_ena && lut_addr >= INIT_LEN ##1 lut_ena |=> lut_data == '0;
   endproperty
   a_zero: assert property (p_zero)
      else $error("entry past the initial array is not zero");
   property p_exact; !init_inexact; endproperty
   a_exact: assert property (p_exact)
      else $error("representable contents flagged as inexact");
   property p_ack_pulse; wb_rsp.ack |=> !wb_rsp.ack; endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("bus ack longer than one cycle");
   property p_ack_time; $rose(wb_req.stb) |=> wb_rsp.ack; endproperty
   a_ack_time: assert property (p_ack_time)
      else $error("bus ack not one cycle after request");
   property p_unmap; rd_take && wb_req.adr == 8'h18 |=> wb_rsp.dat == '0;
   endproperty
   a_unmap: assert property (p_unmap)
      else $error("unmapped read is not zero");
   property p_view;
      rd_take && wb_req.adr == LUTROM_REG_DATA && !lut_ena
      |=> wb_rsp.dat == 32'($signed($past(lut_data)));
   endproperty
   a_view: assert property (p_view)
      else $error("data view is not the sign-extended word");
   c_stall: cover property (lut_ena ##1 !lut_ena [*3]);
   c_read: cover property (rd_take ##1 wb_rsp.ack);
   c_write: cover property (wb_req.we && wb_rsp.ack);
endmodule : lutrom_checker
`default_nettype wire

/* File: bench/lutrom_feed.sv */
// Upstream datapath model that steps the lookup address each enabled cycle.
`timescale 1ns/1ps
`default_nettype none
module lutrom_feed
#(
   parameter int ADDR_W = 3
)
(
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              sys_rst,
   // Control from the bench
   input  wire logic              run,
   // Lookup side
   output var  logic [ADDR_W-1:0] lut_addr,
   output var  logic              lut_ena
);
   logic [ADDR_W-1:0] addr_q;
   assign lut_addr = addr_q;
   assign lut_ena  = run;
   // The address wraps as an unsigned count.
   always_ff @(posedge clk_sys)
      if (sys_rst) addr_q <= '0;
      else if (run) addr_q <= addr_q + 1'b1;
endmodule : lutrom_feed
`default_nettype wire

/* File: bench/tb_lutrom_top.sv */
// Self-checking bench for the look-up table block.
`timescale 1ns/1ps
`default_nettype none
module tb_lutrom_top
   import lutrom_pkg::*;
;
   logic              clk_sys = 1'b0;
   logic              sys_rst = 1'b1;
   logic              run = 1'b0;
   logic [2:0]        lut_addr;
   logic              lut_ena;
   logic [5:0]        lut_data;
   logic              init_inexact;
   lutrom_wb_req_type wb_req = '0;
   lutrom_wb_rsp_type wb_rsp;
   logic [31:0]       rd;
   int                fail_count = 0;
   int                tests_run = 0;
   // Expected word for each address of the three-bit table.
   localparam logic [5:0] ROWS [8] =
      '{6'h05, 6'h3D, 6'h1F, 6'h20, 6'h00, 6'h00, 6'h00, 6'h00};
   localparam logic signed [31:0] VALS [4] = '{5, -3, 31, -32};
   // Build choices of the block under test.
   localparam int TB_ADDR_W = 3;
   localparam int TB_INT    = 4;
   localparam int TB_FRAC   = 2;
   localparam int TB_LEN    = 4;
   localparam bit TB_RADDR  = 1'b1;

   always #5 clk_sys = ~clk_sys;

   lutrom_feed #(.ADDR_W(TB_ADDR_W)) lutrom_feed_inst (.clk_sys(clk_sys),
      .sys_rst(sys_rst), .run(run), .lut_addr(lut_addr), .lut_ena(lut_ena));
   lutrom_top #(.ADDR_W(TB_ADDR_W), .FMT(LUTROM_SFRAC), .INT_BITS(TB_INT),
      .FRAC_BITS(TB_FRAC), .REG_ADDR(TB_RADDR), .INIT_LEN(TB_LEN),
      .INIT_VALS(VALS)) lutrom_top_inst (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .lut_addr(lut_addr),
      .lut_ena(lut_ena), .lut_data(lut_data), .wb_req(wb_req),
      .wb_rsp(wb_rsp), .init_inexact(init_inexact));

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : give_verdict

   task automatic chk6(input string n, input logic [5:0] e, s);
      tests_run++;
      if (s !== e)
      begin
         fail_count++;
         $display("BAD %s exp %h seen %h", n, e, s);
      end
   endtask : chk6

   task automatic chk32(input string n, input logic [31:0] e, s);
      tests_run++;
      if (s !== e)
      begin
         fail_count++;
         $display("BAD %s exp %h seen %h", n, e, s);
      end
   endtask : chk32

   // One classic cycle; waits for ack under a bounded count.
   task automatic wb(input logic [7:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clk_sys);
      wb_req <= '{1'b1, 1'b1, w, a, 4'hF, d};
      do
         @(posedge clk_sys);
      while (wb_rsp.ack !== 1'b1 && ++n < 50);
      if (n >= 50)
         fail_count++;
      r = wb_rsp.dat;
      wb_req <= '0;
   endtask : wb

   initial
   begin
      #20000;
      fail_count++;
      give_verdict();
   end

   initial
   begin
      repeat (4) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      #1 chk6("reset data", 6'h00, lut_data);
      chk32("inexact", 32'h0, {31'h0, init_inexact});
      run <= 1'b1;
      @(posedge clk_sys);
      for (int i = 0; i < 11; i++)
      begin
         @(posedge clk_sys);
         #1 chk6("lut_data", ROWS[i % 8], lut_data);
      end
      @(posedge clk_sys);
      run <= 1'b0;
      repeat (3) @(posedge clk_sys);
      #1 chk6("held data", 6'h20, lut_data);
      wb(LUTROM_REG_DATA, 1'b0, 32'h0, rd);
      chk32("data view", 32'hFFFF_FFE0, rd);
      wb(LUTROM_REG_INFO, 1'b0, 32'h0, rd);
      chk32("info", 32'h0202_0103, rd);
      wb(LUTROM_REG_SADDR, 1'b1, 32'h5, rd);
      wb(LUTROM_REG_SADDR, 1'b0, 32'h0, rd);
      chk32("saddr", 32'h5, rd);
      wb(8'h18, 1'b0, 32'h0, rd);
      chk32("unmapped", 32'h0, rd);
      wb(LUTROM_REG_COUNT, 1'b1, 32'h0, rd);
      wb(LUTROM_REG_COUNT, 1'b0, 32'h0, rd);
      chk32("count", 32'h0, rd);
      wb(LUTROM_REG_CTRL, 1'b1, 32'h1, rd);
      wb(LUTROM_REG_CTRL, 1'b0, 32'h0, rd);
      chk32("ctrl", 32'h1, rd);
      wb(LUTROM_REG_STATUS, 1'b0, 32'h0, rd);
      chk32("status", 32'h0, rd);
      wb(LUTROM_REG_CTRL, 1'b1, 32'h0, rd);
      @(posedge clk_sys);
      run <= 1'b1;
      repeat (5) @(posedge clk_sys);
      #1 chk6("resumed", ROWS[0], lut_data);
      @(posedge clk_sys);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      #1 chk6("mid reset", 6'h00, lut_data);
      give_verdict();
   end
endmodule : tb_lutrom_top

bind lutrom_top lutrom_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W),
   .INIT_LEN(INIT_LEN)) lutrom_checker_inst (.clk_sys(clk_sys),
   .sys_rst(sys_rst), .lut_addr(lut_addr), .lut_ena(lut_ena),
   .lut_data(lut_data), .wb_req(wb_req), .wb_rsp(wb_rsp),
   .init_inexact(init_inexact));
`default_nettype wire
